// ==== ees_mst.sv ====
// Behavioural two-wire bus master that drives the serial clock and data.
`timescale 1ns/1ps
module ees_mst (
	input  wire logic clk,
	input  wire logic sda_wire,
	output logic      scl,
	output logic      sda_low
);

	////////////////////////////////////////
	// The bus idles with the clock high and the data line left to its pull-up.
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	////////////////////////////////////////
	// Start from idle or as a repeated start; data falls with clock high.
	task automatic start();
		@(posedge clk);
		sda_low <= 1'b0;
		repeat (2) @(posedge clk);
		scl <= 1'b1;
		repeat (4) @(posedge clk);
		sda_low <= 1'b1;
		repeat (4) @(posedge clk);
		scl <= 1'b0;
		@(posedge clk);
	endtask

	// One bit of 160 ns; data only moves while the clock is low.
	task automatic clock_bit(input logic b, output logic seen);
		@(posedge clk);
		sda_low <= ~b;
		repeat (2) @(posedge clk);
		scl <= 1'b1;
		repeat (4) @(posedge clk);
		seen = sda_wire;
		scl <= 1'b0;
		@(posedge clk);
	endtask

	// Byte out, most significant bit first, then the ninth bit released.
	task automatic send_byte(input logic [7:0] v, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			clock_bit(v[i], s);
		clock_bit(1'b1, s);
		ack = ~s;
	endtask

	// Byte in; the master answers in the ninth bit, nack before a stop.
	task automatic get_byte(input logic nack, output logic [7:0] v);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clock_bit(1'b1, s);
			v[i] = s;
		end
		clock_bit(nack, s);
	endtask

	// Stop: data rises while the clock is high, then the bus rests.
	task automatic stop();
		@(posedge clk);
		sda_low <= 1'b1;
		repeat (2) @(posedge clk);
		scl <= 1'b1;
		repeat (4) @(posedge clk);
		sda_low <= 1'b0;
		repeat (8) @(posedge clk);
	endtask

endmodule

// ==== ees_pkg.sv ====
// Shared constants, types and helpers for the EEPROM select and protect front end.
package ees_pkg;

	// Density variants; three codes of the field are unused and illegal.
	typedef enum logic [2:0] {
		DEN_1K,
		DEN_2K,
		DEN_4K,
		DEN_8K,
		DEN_16K
	} ees_density_type;

	// Byte address width of the largest variant, 2048 bytes.
	localparam int unsigned ADDR_W     = 11;
	localparam logic [3:0]  BYTE_BITS  = 4'h8;
	localparam logic [3:0]  BIT_CNT_RST = 4'h0;
	localparam logic [3:0]  STOP_SLOT_MAX = 4'h1;

	// Field positions inside the select byte, sent b7 first.
	localparam int unsigned SEL_ID_MSB = 7;
	localparam int unsigned SEL_ID_LSB = 4;
	localparam int unsigned SEL_CS_MSB = 3;
	localparam int unsigned SEL_CS_LSB = 1;
	localparam int unsigned SEL_RW_BIT = 0;
	localparam logic        RW_READ    = 1'b1;

	// Type identifier default; the value is arbitrary.
	localparam logic [3:0]  TYPE_ID_RST = 4'h6;

	// Address masks giving 128, 256, 512, 1024 and 2048 bytes.
	localparam logic [ADDR_W-1:0] MASK_1K  = 11'h07F;
	localparam logic [ADDR_W-1:0] MASK_2K  = 11'h0FF;
	localparam logic [ADDR_W-1:0] MASK_4K  = 11'h1FF;
	localparam logic [ADDR_W-1:0] MASK_8K  = 11'h3FF;
	localparam logic [ADDR_W-1:0] MASK_16K = 11'h7FF;

	// Which select positions b3..b1 still act as chip-select bits.
	localparam logic [2:0] CS_USE_SMALL = 3'h7;
	localparam logic [2:0] CS_USE_4K    = 3'h6;
	localparam logic [2:0] CS_USE_8K    = 3'h4;
	localparam logic [2:0] CS_USE_16K   = 3'h0;

	// Reset values.
	localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;
	localparam logic [7:0]        BYTE_RST = 8'h00;

	// Address mask of a density variant; illegal codes fall back to 1 Kbit.
	function automatic logic [ADDR_W-1:0] ees_addr_mask(ees_density_type d);
		unique case (d)
			DEN_1K:  return MASK_1K;
			DEN_2K:  return MASK_2K;
			DEN_4K:  return MASK_4K;
			DEN_8K:  return MASK_8K;
			DEN_16K: return MASK_16K;
			default: return MASK_1K;
		endcase
	endfunction

	// Chip-select positions compared for a density variant.
	function automatic logic [2:0] ees_cs_use(ees_density_type d);
		unique case (d)
			DEN_1K:  return CS_USE_SMALL;
			DEN_2K:  return CS_USE_SMALL;
			DEN_4K:  return CS_USE_4K;
			DEN_8K:  return CS_USE_8K;
			DEN_16K: return CS_USE_16K;
			default: return CS_USE_SMALL;
		endcase
	endfunction

endpackage

// ==== ees_select_match.sv ====
// Select byte decoder: type identifier, chip-select match and upper address.
`timescale 1ns/1ps
module ees_select_match
	import ees_pkg::*;
(
	input  wire logic [7:1]      sel_code,
	input  wire logic [2:0]      cs_pins,
	input  wire ees_density_type density,
	input  wire logic [3:0]      type_id,
	output logic                 match,
	output logic [2:0]           upper_bits
);

	logic [2:0] cs_use;
	logic [2:0] cs_code;

	// Positions taken by address bits are masked out of the compare.
	assign cs_use     = ees_cs_use(density);
	assign cs_code    = sel_code[SEL_CS_MSB:SEL_CS_LSB];
	assign upper_bits = cs_code & ~cs_use;
	assign match      = (sel_code[SEL_ID_MSB:SEL_ID_LSB] == type_id) &&
		((cs_code & cs_use) == (cs_pins & cs_use));

endmodule

// ==== ees_sync.sv ====
// Two-stage synchroniser for levels arriving from outside the clock domain.
`timescale 1ns/1ps
module ees_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] d_in,
	output logic      [WIDTH-1:0] q_out
);

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] hold_ff;

	// The first stage is read only by the second stage.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_ff <= '0;
			hold_ff <= '0;
		end else begin
			meta_ff <= d_in;
			hold_ff <= meta_ff;
		end
	end

	assign q_out = hold_ff;

endmodule

// ==== ees_top.sv ====
// Serial EEPROM bus front end: select decode, acknowledge, write protect.
`timescale 1ns/1ps
// Notes on behaviour
// - Capacity 2048 down to 128 bytes per variant.
// - Fixed four-bit type identifier checked against b7..b4.
// - Access opens with Start, select byte, acknowledge.
// - Device acknowledges in ninth bit when receiving.
// - All transfers timed by the master's serial clock.
// - Data line driven low only, open drain.
// - Chip-select pins compared against those of b3, b2, b1 not used as address.
// - Floating chip-select pins read as zero.
// - Write protect high blocks all array writes; the code only counts the level seen from Start to the end of the address byte.
// - Floating write protect reads low, writes allowed.
// - Protected: select, address acked; data bytes nacked.
// - Bus ignored until power-on reset releases.
// - Power-on reset clears state, enters standby.
// - Below threshold, device stops responding immediately.
// - Stop enters standby unless write cycle running; the code also shows standby while write_busy is high.
// - Dense variants use b3..b1 as upper address.
// - Select byte sent MSB first, b0 is read/write.
// - Read/write flag one means read, zero write.
// - Select mismatch: no acknowledge, return to standby.
// - Start is data falling while clock high.
// - Stop is data rising while clock high.
module ees_top
	import ees_pkg::*;
#(
	parameter logic [3:0] TYPE_ID = TYPE_ID_RST
) (
	input  wire logic                   clk,
	input  wire logic                   rst_b,
	input  wire logic                   scl_pin,
	input  wire logic                   sda_in,
	output logic                        sda_out,
	output logic                        sda_oe,
	input  wire logic                   chip_select_pin_0,
	input  wire logic                   chip_select_pin_1,
	input  wire logic                   chip_select_pin_2,
	input  wire logic                   write_protect_input,
	input  wire ees_pkg::ees_density_type density,
	input  wire logic                   write_busy,
	input  wire logic [7:0]             rd_data,
	output logic                        standby,
	output logic [ees_pkg::ADDR_W-1:0]  mem_addr,
	output logic [7:0]                  wr_data,
	output logic                        wr_strobe,
	output logic                        write_start
);

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_DEV_BYTE,
		ST_DEV_ACK,
		ST_ADDR_BYTE,
		ST_ADDR_ACK,
		ST_DATA_IN,
		ST_DATA_ACK,
		ST_DATA_OUT,
		ST_MACK,
		ST_WAIT_STOP
	} ees_state_type;

	ees_state_type     st_ff,     nxt_st;
	logic [3:0]        cnt_ff,    nxt_cnt;
	logic [7:0]        sh_ff,     nxt_sh;
	logic              oe_ff,     nxt_oe;
	logic [ADDR_W-1:0] addr_ff,   nxt_addr;
	logic              wp_ff,     nxt_wp;
	logic              rw_ff,     nxt_rw;
	logic              wrote_ff,  nxt_wrote;
	logic              mack_ff,   nxt_mack;
	logic              strobe_ff, nxt_strobe;
	logic              wstart_ff, nxt_wstart;
	logic [7:0]        wdata_ff,  nxt_wdata;
	logic              stby_ff,   nxt_stby;
	logic              out_ff;
	logic              scl_d_ff;
	logic              sda_d_ff;

	logic [1:0]        bus_s;
	logic [3:0]        strap_s;
	logic              scl_s;
	logic              sda_s;
	logic              scl_rise;
	logic              scl_fall;
	logic              start_ev;
	logic              stop_ev;
	logic              sel_match;
	logic [2:0]        sel_upper;
	logic [ADDR_W-1:0] addr_mask;
	logic [ADDR_W-1:0] addr_inc;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers. Unconnected strap pins rely on pad pull-downs, so
	// they arrive here as zero.
	ees_sync #(.WIDTH(2)) u_bus_sync (
		.clk   (clk),
		.rst_b (rst_b),
		.d_in  ({scl_pin, sda_in}),
		.q_out (bus_s)
	);

	ees_sync #(.WIDTH(4)) u_strap_sync (
		.clk   (clk),
		.rst_b (rst_b),
		.d_in  ({write_protect_input, chip_select_pin_2,
			chip_select_pin_1, chip_select_pin_0}),
		.q_out (strap_s)
	);

	// The serial clock is only sampled; its edges pace every bit.
	assign scl_s    = bus_s[1];
	assign sda_s    = bus_s[0];
	assign scl_rise = scl_s && !scl_d_ff;
	assign scl_fall = !scl_s && scl_d_ff;
	assign start_ev = scl_s && scl_d_ff && sda_d_ff && !sda_s;
	assign stop_ev  = scl_s && scl_d_ff && !sda_d_ff && sda_s;

	////////////////////////////////////////////////////////////////////////
	// Select byte decode from the shifted bits b7..b1.
	ees_select_match u_match (
		.sel_code   (sh_ff[7:1]),
		.cs_pins    (strap_s[2:0]),
		.density    (density),
		.type_id    (TYPE_ID),
		.match      (sel_match),
		.upper_bits (sel_upper)
	);

	// Every address update is masked to the capacity of the chosen variant.
	assign addr_mask = ees_addr_mask(density);
	assign addr_inc  = (addr_ff + 11'h001) & addr_mask;

	////////////////////////////////////////////////////////////////////////
	// Protocol sequencer. A running write cycle outranks everything, then
	// Stop, then Start, so a framing event is never lost to a bit edge.
	always_comb begin
		nxt_st     = st_ff;
		nxt_cnt    = cnt_ff;
		nxt_sh     = sh_ff;
		nxt_oe     = oe_ff;
		nxt_addr   = addr_ff;
		nxt_wp     = wp_ff;
		nxt_rw     = rw_ff;
		nxt_wrote  = wrote_ff;
		nxt_mack   = mack_ff;
		nxt_wdata  = wdata_ff;
		nxt_strobe = 1'b0;
		nxt_wstart = 1'b0;
		if (write_busy) begin
			nxt_st = ST_IDLE;
			nxt_oe = 1'b0;
		end else if (stop_ev) begin
			// Only a Stop straight after a data acknowledge commits data.
			if (st_ff == ST_DATA_IN && cnt_ff <= STOP_SLOT_MAX && wrote_ff) begin
				nxt_wstart = 1'b1;
			end
			nxt_st    = ST_IDLE;
			nxt_oe    = 1'b0;
			nxt_wrote = 1'b0;
		end else if (start_ev) begin
			nxt_st    = ST_DEV_BYTE;
			nxt_cnt   = BIT_CNT_RST;
			nxt_oe    = 1'b0;
			nxt_wrote = 1'b0;
			nxt_wp    = strap_s[3];
		end else begin
			unique case (st_ff)
				ST_IDLE, ST_WAIT_STOP: begin
					nxt_oe = 1'b0;
				end
				ST_DEV_BYTE, ST_ADDR_BYTE, ST_DATA_IN: begin
					// Protect level is gathered until the address byte ends.
					if (st_ff != ST_DATA_IN) begin
						nxt_wp = wp_ff | strap_s[3];
					end
					if (scl_rise && cnt_ff != BYTE_BITS) begin
						nxt_sh  = {sh_ff[6:0], sda_s};
						nxt_cnt = cnt_ff + 4'h1;
					end else if (scl_fall && cnt_ff == BYTE_BITS) begin
						nxt_cnt = BIT_CNT_RST;
						if (st_ff == ST_DEV_BYTE) begin
							if (sel_match) begin
								nxt_st   = ST_DEV_ACK;
								nxt_oe   = 1'b1;
								nxt_rw   = sh_ff[SEL_RW_BIT];
								nxt_addr = {sel_upper, addr_ff[7:0]} & addr_mask;
							end else begin
								nxt_st = ST_IDLE;
							end
						end else if (st_ff == ST_ADDR_BYTE) begin
							nxt_st   = ST_ADDR_ACK;
							nxt_oe   = 1'b1;
							nxt_addr = {addr_ff[10:8], sh_ff} & addr_mask;
						end else begin
							nxt_st = ST_DATA_ACK;
							nxt_oe = !wp_ff;
							if (!wp_ff) begin
								nxt_strobe = 1'b1;
								nxt_wdata  = sh_ff;
								nxt_wrote  = 1'b1;
							end
						end
					end
				end
				ST_DEV_ACK, ST_ADDR_ACK, ST_DATA_ACK: begin
					if (scl_fall) begin
						nxt_oe = 1'b0;
						if (st_ff == ST_DEV_ACK && rw_ff == RW_READ) begin
							nxt_st  = ST_DATA_OUT;
							nxt_sh  = rd_data;
							nxt_oe  = !rd_data[7];
							nxt_cnt = BIT_CNT_RST;
						end else if (st_ff == ST_DEV_ACK) begin
							nxt_st = ST_ADDR_BYTE;
						end else begin
							nxt_st = ST_DATA_IN;
							// Page writes advance only the low four bits.
							if (st_ff == ST_DATA_ACK && !wp_ff) begin
								nxt_addr = {addr_ff[10:4], addr_ff[3:0] + 4'h1}
									& addr_mask;
							end
						end
					end
				end
				ST_DATA_OUT: begin
					if (scl_rise) begin
						nxt_cnt = cnt_ff + 4'h1;
					end else if (scl_fall && cnt_ff == BYTE_BITS) begin
						nxt_oe   = 1'b0;
						nxt_st   = ST_MACK;
						nxt_cnt  = BIT_CNT_RST;
						nxt_mack = 1'b0;
					end else if (scl_fall && cnt_ff != BIT_CNT_RST) begin
						nxt_sh = {sh_ff[6:0], 1'b0};
						nxt_oe = !sh_ff[6];
					end
				end
				ST_MACK: begin
					// Advancing on the rising edge lets the array settle
					// before the next byte is loaded on the falling edge.
					if (scl_rise) begin
						if (!sda_s) begin
							nxt_mack = 1'b1;
							nxt_addr = addr_inc;
						end else begin
							nxt_st = ST_WAIT_STOP;
						end
					end else if (scl_fall && mack_ff) begin
						nxt_st  = ST_DATA_OUT;
						nxt_sh  = rd_data;
						nxt_oe  = !rd_data[7];
						nxt_cnt = BIT_CNT_RST;
					end
				end
				default: begin
					nxt_st = ST_IDLE;
					nxt_oe = 1'b0;
				end
			endcase
		end
		nxt_stby = (nxt_st == ST_IDLE);
	end

	// Power-on reset holds the whole block silent in standby.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_ff     <= ST_IDLE;
			cnt_ff    <= BIT_CNT_RST;
			sh_ff     <= BYTE_RST;
			oe_ff     <= 1'b0;
			addr_ff   <= ADDR_RST;
			wp_ff     <= 1'b0;
			rw_ff     <= 1'b0;
			wrote_ff  <= 1'b0;
			mack_ff   <= 1'b0;
			strobe_ff <= 1'b0;
			wstart_ff <= 1'b0;
			wdata_ff  <= BYTE_RST;
			stby_ff   <= 1'b1;
			out_ff    <= 1'b0;
			scl_d_ff  <= 1'b0;
			sda_d_ff  <= 1'b0;
		end else begin
			st_ff     <= nxt_st;
			cnt_ff    <= nxt_cnt;
			sh_ff     <= nxt_sh;
			oe_ff     <= nxt_oe;
			addr_ff   <= nxt_addr;
			wp_ff     <= nxt_wp;
			rw_ff     <= nxt_rw;
			wrote_ff  <= nxt_wrote;
			mack_ff   <= nxt_mack;
			strobe_ff <= nxt_strobe;
			wstart_ff <= nxt_wstart;
			wdata_ff  <= nxt_wdata;
			stby_ff   <= nxt_stby;
			out_ff    <= 1'b0;
			scl_d_ff  <= scl_s;
			sda_d_ff  <= sda_s;
		end
	end

	// Outputs come straight from flops.
	assign sda_out     = out_ff;
	assign sda_oe      = oe_ff;
	assign standby     = stby_ff;
	assign mem_addr    = addr_ff;
	assign wr_data     = wdata_ff;
	assign wr_strobe   = strobe_ff;
	assign write_start = wstart_ff;

	////////////////////////////////////////////////////////////////////////
	// Checks on the sequencer.
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	open_drain_a: assert property (!sda_out)
		else $error("data line driven high");

	nomatch_quiet_a: assert property (
		st_ff == ST_DEV_BYTE && scl_fall && cnt_ff == BYTE_BITS &&
		!sel_match && !write_busy && !stop_ev && !start_ev
		|=> standby && !sda_oe)
		else $error("mismatched select byte was acknowledged");

	ninth_ack_a: assert property (
		st_ff == ST_ADDR_BYTE && scl_fall && cnt_ff == BYTE_BITS &&
		!write_busy && !stop_ev && !start_ev
		|=> sda_oe && st_ff == ST_ADDR_ACK)
		else $error("no acknowledge after address byte");

	protect_nack_a: assert property (
		st_ff == ST_DATA_ACK |-> sda_oe == !wp_ff)
		else $error("data acknowledge disagrees with protect");

	protect_write_a: assert property (wr_strobe |-> !wp_ff)
		else $error("array write while protected");

	start_frame_a: assert property (
		start_ev && !write_busy && !stop_ev
		|=> st_ff == ST_DEV_BYTE && cnt_ff == BIT_CNT_RST && !sda_oe)
		else $error("start did not open a select byte");

	stop_standby_a: assert property (
		stop_ev |=> standby && !sda_oe)
		else $error("stop did not return to standby");

	busy_ignore_a: assert property (
		write_busy [*2] |-> standby && !sda_oe && !wr_strobe)
		else $error("bus answered during write cycle");

	msb_shift_a: assert property (
		st_ff == ST_DEV_BYTE && scl_rise && cnt_ff != BYTE_BITS &&
		!write_busy && !stop_ev && !start_ev
		|=> sh_ff[0] == $past(sda_s) && sh_ff[7:1] == $past(sh_ff[6:0]))
		else $error("select byte not shifted msb first");

	rw_flag_a: assert property (
		st_ff == ST_DEV_ACK && scl_fall && rw_ff && !write_busy &&
		!stop_ev && !start_ev |=> st_ff == ST_DATA_OUT)
		else $error("read flag did not start a read");

	addr_range_a: assert property ((mem_addr & ~addr_mask) == 11'h000)
		else $error("address beyond variant capacity");

endmodule

// ==== tb_top.sv ====
// Self-checking bench for the EEPROM select and protect front end.
`timescale 1ns/1ps
module tb_top;
	import ees_pkg::*;

	// Type identifier of the bench device; the value is arbitrary.
	localparam logic [3:0] ID = 4'h9;

	logic                 clk;
	logic                 rst_b;
	logic                 scl;
	logic                 sda_low;
	logic                 sda_wire;
	logic                 sda_out;
	logic                 sda_oe;
	logic [2:0]           cs;
	logic                 wp;
	logic                 busy;
	ees_density_type      den;
	logic [7:0]           rd_data;
	logic                 standby;
	logic [ADDR_W-1:0]    mem_addr;
	logic [7:0]           wr_data;
	logic [7:0]           last_wr;
	logic                 wr_strobe;
	logic                 write_start;
	int                   n_errors;
	int                   checked;
	int                   n_strobe;
	int                   n_commit;

	////////////////////////////////////////
	// Wired data line with pull-up: low if either party pulls it.
	assign sda_wire = (sda_oe ? sda_out : 1'b1) & ~sda_low;

	ees_top #(.TYPE_ID(ID)) ees_top_i (
		.clk                 (clk),
		.rst_b               (rst_b),
		.scl_pin             (scl),
		.sda_in              (sda_wire),
		.sda_out             (sda_out),
		.sda_oe              (sda_oe),
		.chip_select_pin_0   (cs[0]),
		.chip_select_pin_1   (cs[1]),
		.chip_select_pin_2   (cs[2]),
		.write_protect_input (wp),
		.density             (den),
		.write_busy          (busy),
		.rd_data             (rd_data),
		.standby             (standby),
		.mem_addr            (mem_addr),
		.wr_data             (wr_data),
		.wr_strobe           (wr_strobe),
		.write_start         (write_start)
	);

	ees_mst ees_mst_i (
		.clk      (clk),
		.sda_wire (sda_wire),
		.scl      (scl),
		.sda_low  (sda_low)
	);

	always #10 clk = ~clk;

	////////////////////////////////////////
	// Array stand-in: data lags the address by one clock, as allowed.
	always @(posedge clk) begin
		if (wr_strobe === 1'b1) begin
			n_strobe <= n_strobe + 1;
			last_wr <= wr_data;
		end
		if (write_start === 1'b1)
			n_commit <= n_commit + 1;
		rd_data <= mem_addr[7:0] ^ 8'h5A;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Start followed by a select byte for this device.
	task automatic sel(input logic [2:0] c, input logic rw, output logic a);
		ees_mst_i.start();
		ees_mst_i.send_byte({ID, c, rw}, a);
	endtask

	////////////////////////////////////////
	// Reset values, then a reset in mid-transfer that must drop the access.
	task automatic t_por();
		logic a;
		int   s0;
		s0 = n_strobe;
		check(standby, 1'b1);
		check(sda_oe, 1'b0);
		check(mem_addr, 11'h000);
		sel(3'h5, 1'b0, a);
		ees_mst_i.send_byte(8'h12, a);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		check(standby, 1'b1);
		check(mem_addr, 11'h000);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		ees_mst_i.send_byte(8'h77, a);
		check(a, 1'b0);
		ees_mst_i.stop();
		check(n_strobe, s0);
		$display("reset test done");
	endtask

	// Page write that wraps at the low-nibble boundary, committed by the stop.
	task automatic t_write();
		logic a;
		int   s0;
		int   c0;
		s0 = n_strobe;
		c0 = n_commit;
		sel(3'h5, 1'b0, a);
		check(a, 1'b1);
		ees_mst_i.send_byte(8'h3F, a);
		check(a, 1'b1);
		check(mem_addr, 11'h03F);
		ees_mst_i.send_byte(8'hC3, a);
		check(a, 1'b1);
		// The byte is handed on when its eighth bit ends, before its ack.
		check(last_wr, 8'hC3);
		ees_mst_i.send_byte(8'h81, a);
		check(last_wr, 8'h81);
		ees_mst_i.stop();
		check(last_wr, 8'h81);
		check(n_strobe - s0, 2);
		check(mem_addr, 11'h031);
		check(n_commit - c0, 1);
		check(standby, 1'b1);
		$display("write test done");
	endtask

	// Wrong identifier or chip select: no ack and the bus is ignored.
	task automatic t_mismatch();
		logic a;
		ees_mst_i.start();
		ees_mst_i.send_byte({ID ^ 4'h8, 3'h5, 1'b0}, a);
		check(a, 1'b0);
		sel(3'h4, 1'b0, a);
		check(a, 1'b0);
		ees_mst_i.send_byte(8'h00, a);
		check(a, 1'b0);
		check(standby, 1'b1);
		ees_mst_i.stop();
		$display("mismatch test done");
	endtask

	// Dense variants take upper address bits and ignore those pins.
	task automatic t_density();
		logic            a;
		int              c0;
		logic [2:0]      u [3] = '{3'h6, 3'h4, 3'h0};
		ees_density_type d [3] = '{DEN_4K, DEN_8K, DEN_16K};
		c0 = n_commit;
		// The smallest variant keeps all pins and only seven address bits.
		den <= DEN_1K;
		sel(3'h5, 1'b0, a);
		check(a, 1'b1);
		ees_mst_i.send_byte(8'h91, a);
		check(mem_addr, 11'h011);
		ees_mst_i.stop();
		cs <= 3'h0;
		for (int k = 0; k < 3; k++) begin
			den <= d[k];
			sel(~u[k], 1'b0, a);
			check(a, 1'b1);
			ees_mst_i.send_byte(8'h11, a);
			check(mem_addr, {~u[k], 8'h11});
			ees_mst_i.stop();
		end
		// Bring the address back into the small range before the mask
		// narrows again, or the address would sit beyond the capacity.
		sel(3'h0, 1'b0, a);
		ees_mst_i.send_byte(8'h00, a);
		check(mem_addr, 11'h000);
		ees_mst_i.stop();
		check(n_commit, c0);
		den <= DEN_2K;
		cs <= 3'h5;
		$display("density test done");
	endtask

	// Protected: select and address acked, data nacked and not passed on.
	task automatic t_protect();
		logic a;
		int   s0;
		s0 = n_strobe;
		wp <= 1'b1;
		sel(3'h5, 1'b0, a);
		check(a, 1'b1);
		ees_mst_i.send_byte(8'h07, a);
		check(a, 1'b1);
		ees_mst_i.send_byte(8'hAA, a);
		check(a, 1'b0);
		ees_mst_i.stop();
		check(n_strobe, s0);
		wp <= 1'b0;
		$display("protect test done");
	endtask

	// Random read at the top address; the second byte wraps to zero.
	task automatic t_read();
		logic       a;
		logic [7:0] v;
		sel(3'h5, 1'b0, a);
		ees_mst_i.send_byte(8'hFF, a);
		sel(3'h5, 1'b1, a);
		check(a, 1'b1);
		ees_mst_i.get_byte(1'b0, v);
		check(v, 8'hFF ^ 8'h5A);
		ees_mst_i.get_byte(1'b1, v);
		check(v, 8'h00 ^ 8'h5A);
		ees_mst_i.stop();
		check(sda_oe, 1'b0);
		check(standby, 1'b1);
		$display("read test done");
	endtask

	// A running write cycle leaves the bus unanswered.
	task automatic t_busy();
		logic a;
		busy <= 1'b1;
		sel(3'h5, 1'b0, a);
		check(a, 1'b0);
		ees_mst_i.stop();
		busy <= 1'b0;
		$display("busy test done");
	endtask

	////////////////////////////////////////
	// Main sequence; the watchdog below cuts a hang short.
	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		cs = 3'h5;
		wp = 1'b0;
		busy = 1'b0;
		den = DEN_2K;
		rd_data = 8'h00;
		last_wr = 8'h00;
		n_errors = 0;
		checked = 0;
		n_strobe = 0;
		n_commit = 0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		t_por();
		t_write();
		t_mismatch();
		t_density();
		t_protect();
		t_read();
		t_busy();
		results();
	end

	initial begin
		repeat (100000) @(posedge clk);
		n_errors++;
		results();
	end

endmodule
